// [hdl/mie_consts.vh]
// mie_consts.vh: constants of the instruction execute block
// assumes: included by hdl/mie_exec.v and by the checker and bench
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
// ----------------------------------------------------------------
// operation codes on op_code
// ----------------------------------------------------------------
`define MIE_OP_NOP      5'h00
`define MIE_OP_BCD_ADJ  5'h01
`define MIE_OP_INC      5'h02
`define MIE_OP_INCREMENT_TO_ACCUMULATOR     5'h03
`define MIE_OP_DEC      5'h04
`define MIE_OP_DECREMENT_TO_ACCUMULATOR     5'h05
`define MIE_OP_PWRDN    5'h06
`define MIE_OP_JUMP     5'h07
`define MIE_OP_MOV_AM   5'h08
`define MIE_OP_MOV_AX   5'h09
`define MIE_OP_MOV_MA   5'h0A
`define MIE_OP_OR_AM    5'h0B
`define MIE_OP_OR_AX    5'h0C
`define MIE_OP_ORM      5'h0D
`define MIE_OP_SUB_EXIT 5'h0E
`define MIE_OP_SUB_EXA  5'h0F
`define MIE_OP_IRQ_EXIT 5'h10
`define MIE_OP_RL       5'h11
`define MIE_OP_RLA      5'h12
`define MIE_OP_RLC      5'h13
`define MIE_OP_RLCA     5'h14
`define MIE_OP_RR       5'h15
`define MIE_OP_RRA      5'h16
`define MIE_OP_RRC      5'h17
`define MIE_OP_RRCA     5'h18
`define MIE_OP_SBC      5'h19
`define MIE_OP_SBCM     5'h1A
`define MIE_OP_DSKIP    5'h1B
// ----------------------------------------------------------------
// arithmetic constants and reset values
// ----------------------------------------------------------------
`define MIE_NIB_MAX     4'h9
`define MIE_NIB_FIX     4'h6
`define MIE_ONE         8'h01
`define MIE_ZERO8       8'h00
`define MIE_PC_RST      11'h000
`define MIE_PC_ONE      11'h001
`endif

// [hdl/mie_exec.v]
// mie_exec.v: execute stage of an 8-bit core, one instruction per slot
// assumes: fetch gives op_code/op_valid with operands; data memory
// read data mem_rdata is valid in the same cycle as the instruction
//
// Operation
// - bcd adjust: low nibble >9 or half carry adds 6
// - bcd adjust: high nibble >9 or carry adds 6
// - bcd adjust result to memory, carry only
// - increment/decrement memory or accumulator, zero flag only
// - power-down stops execution, keeps acc, memory and arithmetic flags
// - power-down clears watchdog, sets pd, clears expiry
// - jump loads pc, two cycles with dummy slot
// - moves copy bytes, no flag change
// - no-operation changes nothing
// - or into accumulator or memory, zero only
// - subroutine exit restores pc, optional accumulator load
// - interrupt exit restores pc, sets global enable
// - pending interrupt served before main program resumes
// - rotate left, bit7 into bit0, no flags
// - rotate left through carry
// - rotate right, bit0 into bit7, no flags
// - rotate right through carry
// - borrow subtract updates ov, z, ac, c
// - subtraction carry clear when negative, set otherwise
// - decrement skip null: zero result skips, two cycles
`include "mie_consts.vh"
`default_nettype none

module mie_exec (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // instruction slot
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire [7:0]  op_imm,
  input  wire [10:0] op_addr,
  // data memory
  input  wire [7:0]  mem_rdata,
  output reg  [7:0]  mem_wdata,
  output reg         mem_we,
  // return stack
  input  wire [10:0] stack_top,
  output wire        stack_pop,
  // interrupt controller
  input  wire        irq_pending,
  output wire        irq_service,
  // wake from power-down
  input  wire        wake,
  // state outputs
  output wire [10:0] pc,
  output wire [7:0]  acc,
  output wire        carry_flag,
  output wire        zero_flag,
  output wire        half_carry_flag,
  output wire        signed_excess_flag,
  output wire        global_irq_enable,
  output wire        power_down_flag,
  output wire        watchdog_expiry_flag,
  output wire        watchdog_clear,
  output wire        clock_off,
  output wire        dummy_slot
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
localparam ST_RUN   = 2'b00;
localparam ST_DUMMY = 2'b01;
localparam ST_HALT  = 2'b10;

reg  [1:0]  state_ff;
reg  [1:0]  nxt_state;
reg  [10:0] pc_ff;
reg  [10:0] nxt_pc;
reg  [7:0]  acc_ff;
reg  [7:0]  nxt_acc;
reg         c_ff;
reg         nxt_c;
reg         z_ff;
reg         nxt_z;
reg         ac_ff;
reg         nxt_ac;
reg         ov_ff;
reg         nxt_ov;
reg         emi_ff;
reg         nxt_emi;
reg         pdf_ff;
reg         nxt_pdf;
reg         to_ff;
reg         nxt_to;
reg         wdt_clr_ff;
reg         nxt_wdt_clr;
reg         irq_svc_ff;
reg         nxt_irq_svc;
reg         pop_c;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [3:0] nib_fix;
  input [3:0] nib;
  input       force_fix;
  begin
    if ((nib > `MIE_NIB_MAX) || force_fix) begin
      nib_fix = `MIE_NIB_FIX;
    end else begin
      nib_fix = 4'h0;
    end
  end
endfunction

// ----------------------------------------------------------------
// datapath
// ----------------------------------------------------------------
// high nibble is judged before the low fix; a low fix that
// carries into a high nibble of 9 is not adjusted again
wire [3:0] lo_add = nib_fix(acc_ff[3:0], ac_ff);
wire [3:0] hi_add = nib_fix(acc_ff[7:4], c_ff);
wire [8:0] bcd_sum = {1'b0, acc_ff} + {1'b0, hi_add, lo_add};
wire [7:0] inc_res = mem_rdata + `MIE_ONE;
wire [7:0] dec_res = mem_rdata - `MIE_ONE;
wire [7:0] or_mem  = acc_ff | mem_rdata;
wire [7:0] or_imm  = acc_ff | op_imm;
wire [7:0] rl_res  = {mem_rdata[6:0], mem_rdata[7]};
wire [7:0] rlc_res = {mem_rdata[6:0], c_ff};
wire [7:0] rr_res  = {mem_rdata[0], mem_rdata[7:1]};
wire [7:0] rrc_res = {c_ff, mem_rdata[7:1]};
// borrow in is the complemented carry
wire       bin     = ~c_ff;
// carry and half carry both read as no borrow out of their stage
wire [8:0] sub_full = {1'b0, acc_ff} - {1'b0, mem_rdata} - {8'h00, bin};
wire [4:0] sub_lo   = {1'b0, acc_ff[3:0]} - {1'b0, mem_rdata[3:0]}
                      - {4'h0, bin};
wire [7:0] sub_res  = sub_full[7:0];
wire       sub_ov   = (acc_ff[7] ^ mem_rdata[7]) & (acc_ff[7] ^ sub_res[7]);

// ----------------------------------------------------------------
// next state
// ----------------------------------------------------------------
always @* begin
  nxt_state   = state_ff;
  nxt_pc      = pc_ff;
  nxt_acc     = acc_ff;
  nxt_c       = c_ff;
  nxt_z       = z_ff;
  nxt_ac      = ac_ff;
  nxt_ov      = ov_ff;
  nxt_emi     = emi_ff;
  nxt_pdf     = pdf_ff;
  nxt_to      = to_ff;
  nxt_wdt_clr = 1'b0;
  nxt_irq_svc = 1'b0;
  mem_we      = 1'b0;
  mem_wdata   = `MIE_ZERO8;
  pop_c       = 1'b0;
  case (state_ff)
    ST_HALT: begin
      // clock gated: nothing moves until wake
      // wake is sampled on the edge, so it must stand over one
      if (wake) begin
        nxt_state = ST_RUN;
      end
    end
    ST_DUMMY: begin
      // dummy slot: the fetched instruction is discarded
      nxt_state = ST_RUN;
      // pending request taken before main program resumes
      if (irq_svc_ff) begin
        nxt_irq_svc = 1'b0;
      end
    end
    default: begin
      if (op_valid) begin
        nxt_pc = pc_ff + `MIE_PC_ONE;
        case (op_code)
          `MIE_OP_NOP: begin
            nxt_pc = pc_ff + `MIE_PC_ONE;
          end
          `MIE_OP_BCD_ADJ: begin
            mem_we    = 1'b1;
            mem_wdata = bcd_sum[7:0];
            // carry only ever set, kept for multi-byte decimal sums
            nxt_c     = c_ff | bcd_sum[8];
          end
          `MIE_OP_INC: begin
            mem_we    = 1'b1;
            mem_wdata = inc_res;
            nxt_z     = (inc_res == `MIE_ZERO8);
          end
          `MIE_OP_INCREMENT_TO_ACCUMULATOR: begin
            nxt_acc = inc_res;
            nxt_z   = (inc_res == `MIE_ZERO8);
          end
          `MIE_OP_DEC: begin
            mem_we    = 1'b1;
            mem_wdata = dec_res;
            nxt_z     = (dec_res == `MIE_ZERO8);
          end
          `MIE_OP_DECREMENT_TO_ACCUMULATOR: begin
            nxt_acc = dec_res;
            nxt_z   = (dec_res == `MIE_ZERO8);
          end
          `MIE_OP_PWRDN: begin
            nxt_state   = ST_HALT;
            nxt_wdt_clr = 1'b1;
            nxt_pdf     = 1'b1;
            nxt_to      = 1'b0;
          end
          `MIE_OP_JUMP: begin
            nxt_pc    = op_addr;
            nxt_state = ST_DUMMY;
          end
          `MIE_OP_MOV_AM: begin
            nxt_acc = mem_rdata;
          end
          `MIE_OP_MOV_AX: begin
            nxt_acc = op_imm;
          end
          `MIE_OP_MOV_MA: begin
            mem_we    = 1'b1;
            mem_wdata = acc_ff;
          end
          `MIE_OP_OR_AM: begin
            nxt_acc = or_mem;
            nxt_z   = (or_mem == `MIE_ZERO8);
          end
          `MIE_OP_OR_AX: begin
            nxt_acc = or_imm;
            nxt_z   = (or_imm == `MIE_ZERO8);
          end
          `MIE_OP_ORM: begin
            mem_we    = 1'b1;
            mem_wdata = or_mem;
            nxt_z     = (or_mem == `MIE_ZERO8);
          end
          // returns refill fetch from the restored pc: one dummy slot
          `MIE_OP_SUB_EXIT: begin
            pop_c     = 1'b1;
            nxt_pc    = stack_top;
            nxt_state = ST_DUMMY;
          end
          `MIE_OP_SUB_EXA: begin
            pop_c     = 1'b1;
            nxt_pc    = stack_top;
            nxt_acc   = op_imm;
            nxt_state = ST_DUMMY;
          end
          // a request seen here is handed on before main code runs
          `MIE_OP_IRQ_EXIT: begin
            pop_c       = 1'b1;
            nxt_pc      = stack_top;
            nxt_emi     = 1'b1;
            nxt_state   = ST_DUMMY;
            nxt_irq_svc = irq_pending;
          end
          `MIE_OP_RL: begin
            mem_we    = 1'b1;
            mem_wdata = rl_res;
          end
          `MIE_OP_RLA: begin
            nxt_acc = rl_res;
          end
          `MIE_OP_RLC: begin
            mem_we    = 1'b1;
            mem_wdata = rlc_res;
            nxt_c     = mem_rdata[7];
          end
          `MIE_OP_RLCA: begin
            nxt_acc = rlc_res;
            nxt_c   = mem_rdata[7];
          end
          `MIE_OP_RR: begin
            mem_we    = 1'b1;
            mem_wdata = rr_res;
          end
          `MIE_OP_RRA: begin
            nxt_acc = rr_res;
          end
          `MIE_OP_RRC: begin
            mem_we    = 1'b1;
            mem_wdata = rrc_res;
            nxt_c     = mem_rdata[0];
          end
          `MIE_OP_RRCA: begin
            nxt_acc = rrc_res;
            nxt_c   = mem_rdata[0];
          end
          `MIE_OP_SBC, `MIE_OP_SBCM: begin
            if (op_code == `MIE_OP_SBCM) begin
              mem_we    = 1'b1;
              mem_wdata = sub_res;
            end else begin
              nxt_acc = sub_res;
            end
            nxt_z  = (sub_res == `MIE_ZERO8);
            nxt_ov = sub_ov;
            nxt_ac = ~sub_lo[4];
            nxt_c  = ~sub_full[8];
          end
          `MIE_OP_DSKIP: begin
            mem_we    = 1'b1;
            mem_wdata = dec_res;
            // skipped word is stepped over by pc and dropped by fetch
            // in the dummy slot; no flag moves here
            if (dec_res == `MIE_ZERO8) begin
              nxt_pc    = pc_ff + `MIE_PC_ONE + `MIE_PC_ONE;
              nxt_state = ST_DUMMY;
            end else begin
              nxt_state = ST_RUN;
            end
          end
          default: begin
            nxt_pc = pc_ff + `MIE_PC_ONE;
          end
        endcase
      end
    end
  endcase
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    state_ff   <= ST_RUN;
    pc_ff      <= `MIE_PC_RST;
    acc_ff     <= `MIE_ZERO8;
    c_ff       <= 1'b0;
    z_ff       <= 1'b0;
    ac_ff      <= 1'b0;
    ov_ff      <= 1'b0;
    emi_ff     <= 1'b0;
    pdf_ff     <= 1'b0;
    to_ff      <= 1'b0;
    wdt_clr_ff <= 1'b0;
    irq_svc_ff <= 1'b0;
  end else begin
    state_ff   <= nxt_state;
    pc_ff      <= nxt_pc;
    acc_ff     <= nxt_acc;
    c_ff       <= nxt_c;
    z_ff       <= nxt_z;
    ac_ff      <= nxt_ac;
    ov_ff      <= nxt_ov;
    emi_ff     <= nxt_emi;
    pdf_ff     <= nxt_pdf;
    to_ff      <= nxt_to;
    wdt_clr_ff <= nxt_wdt_clr;
    irq_svc_ff <= nxt_irq_svc;
  end
end

assign pc                   = pc_ff;
assign acc                  = acc_ff;
assign carry_flag           = c_ff;
assign zero_flag            = z_ff;
assign half_carry_flag      = ac_ff;
assign signed_excess_flag   = ov_ff;
assign global_irq_enable    = emi_ff;
assign power_down_flag      = pdf_ff;
assign watchdog_expiry_flag = to_ff;
assign watchdog_clear       = wdt_clr_ff;
// clock_off only asks for the gate; the gating cell sits outside
assign clock_off            = (state_ff == ST_HALT);
assign dummy_slot           = (state_ff == ST_DUMMY);
assign stack_pop            = pop_c;
assign irq_service          = irq_svc_ff;

endmodule
`default_nettype wire

// [verification/mie_exec_chk.sv]
// mie_exec_chk.sv: port assertions for the execute block
// assumes: bound to mie_exec, one clock, async active-low reset
`include "mie_consts.vh"
`default_nettype none
module mie_exec_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // instruction slot and memory
  input wire logic        op_valid,
  input wire logic [4:0]  op_code,
  input wire logic [10:0] op_addr,
  input wire logic [7:0]  mem_rdata,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_we,
  // return and interrupt
  input wire logic [10:0] stack_top,
  input wire logic        stack_pop,
  input wire logic        irq_pending,
  input wire logic        irq_service,
  // state
  input wire logic [10:0] pc,
  input wire logic        global_irq_enable,
  input wire logic        power_down_flag,
  input wire logic        watchdog_expiry_flag,
  input wire logic        watchdog_clear,
  input wire logic        clock_off,
  input wire logic        dummy_slot
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // refused slots must not trigger anything
  wire tk;
  assign tk = op_valid && !dummy_slot && !clock_off;
  property p_dskip_wr;
    tk && op_code == `MIE_OP_DSKIP
      |-> mem_we && mem_wdata == mem_rdata - 8'h01;
  endproperty
  a_dskip_wr: assert property (p_dskip_wr)
    else $error("skip write bad");
  property p_dskip_skip;
    tk && op_code == `MIE_OP_DSKIP && mem_rdata == 8'h01
      |=> dummy_slot && pc == $past(pc) + 11'h002;
  endproperty
  a_dskip_skip: assert property (p_dskip_skip)
    else $error("skip bad");
  property p_dskip_run;
    tk && op_code == `MIE_OP_DSKIP && mem_rdata != 8'h01
      |=> !dummy_slot && pc == $past(pc) + 11'h001;
  endproperty
  a_dskip_run: assert property (p_dskip_run)
    else $error("no-skip bad");
  property p_jump;
    tk && op_code == `MIE_OP_JUMP
      |=> dummy_slot && pc == $past(op_addr) ##1 !dummy_slot;
  endproperty
  a_jump: assert property (p_jump) else $error("jump bad");
  property p_pwrdn;
    tk && op_code == `MIE_OP_PWRDN |=> clock_off && power_down_flag
      && !watchdog_expiry_flag && watchdog_clear;
  endproperty
  a_pwrdn: assert property (p_pwrdn)
    else $error("power-down bad");
  property p_irq_exit;
    tk && op_code == `MIE_OP_IRQ_EXIT
      |-> stack_pop ##1 global_irq_enable && pc == $past(stack_top);
  endproperty
  a_irq_exit: assert property (p_irq_exit)
    else $error("irq exit bad");
  property p_irq_serv;
    tk && op_code == `MIE_OP_IRQ_EXIT && irq_pending |=> irq_service;
  endproperty
  a_irq_serv: assert property (p_irq_serv)
    else $error("irq serve bad");
  property p_rl_wr;
    tk && op_code == `MIE_OP_RL
      |-> mem_we && mem_wdata == {mem_rdata[6:0], mem_rdata[7]};
  endproperty
  a_rl_wr: assert property (p_rl_wr) else $error("rotate bad");
  c_jump: cover property (tk && op_code == `MIE_OP_JUMP);
  c_skip: cover property (tk && op_code == `MIE_OP_DSKIP && mem_rdata == 8'h01);
  c_pwrdn: cover property (tk && op_code == `MIE_OP_PWRDN);
endmodule
bind mie_exec mie_exec_chk u_chk (.clk(clk), .rstn(rstn),
  .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
  .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
  .stack_top(stack_top), .stack_pop(stack_pop),
  .irq_pending(irq_pending), .irq_service(irq_service), .pc(pc),
  .global_irq_enable(global_irq_enable),
  .power_down_flag(power_down_flag),
  .watchdog_expiry_flag(watchdog_expiry_flag),
  .watchdog_clear(watchdog_clear), .clock_off(clock_off),
  .dummy_slot(dummy_slot));
`default_nettype wire

// [verification/mcu_instruction_execute_tb_top.sv]
// mcu_instruction_execute_tb_top.sv: directed bench for mie_exec
// assumes: memory read data given with the slot, 50 MHz clock
`include "mie_consts.vh"
`default_nettype none
module mcu_instruction_execute_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        op_valid = 1'b0;
  logic [4:0]  op_code = 5'h00;
  logic [7:0]  op_imm = 8'h00;
  logic [10:0] op_addr = 11'h000;
  logic [7:0]  mem_rdata = 8'h00;
  logic [10:0] stack_top = 11'h2AA;
  logic        irq_pending = 1'b0;
  logic        wake = 1'b0;
  wire  [7:0]  mem_wdata, acc;
  wire  [10:0] pc;
  wire         mem_we, stack_pop, irq_service, carry_flag, zero_flag;
  wire         half_carry_flag, signed_excess_flag, global_irq_enable;
  wire         power_down_flag, watchdog_expiry_flag, watchdog_clear;
  wire         clock_off, dummy_slot;
  int          err_count = 0;
  int          checks_done = 0;
  logic        we_s, pop_s, c_m;
  logic [7:0]  wd_s;
  always #10 clk = ~clk;
  mie_exec dut (.clk(clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .op_addr(op_addr),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .stack_top(stack_top), .stack_pop(stack_pop),
    .irq_pending(irq_pending), .irq_service(irq_service), .wake(wake),
    .pc(pc), .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .half_carry_flag(half_carry_flag),
    .signed_excess_flag(signed_excess_flag),
    .global_irq_enable(global_irq_enable),
    .power_down_flag(power_down_flag),
    .watchdog_expiry_flag(watchdog_expiry_flag),
    .watchdog_clear(watchdog_clear), .clock_off(clock_off),
    .dummy_slot(dummy_slot));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // comb outputs are caught 1 ns into the slot, registers after it
  task op(input logic [4:0] c, input logic [7:0] v, input logic [7:0] rd);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_imm <= v;
    op_addr <= {3'h1, v};
    mem_rdata <= rd;
    #1;
    we_s = mem_we;
    wd_s = mem_wdata;
    pop_s = stack_pop;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_bcd;
    logic [7:0] a[3] = '{8'h3C, 8'hA5, 8'h12};
    logic [7:0] e[3] = '{8'h42, 8'h05, 8'h72};
    logic       c[3] = '{1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 3; i++) begin
      op(`MIE_OP_MOV_AX, a[i], 8'h00);
      op(`MIE_OP_BCD_ADJ, 8'h00, 8'h00);
      chk("bcd_data", {we_s, wd_s}, {1'b1, e[i]});
      chk("bcd_c", carry_flag, c[i]);
    end
    c_m = 1'b1;
    $display("test bcd done");
  endtask
  task t_incdec;
    logic [4:0] k[4] = '{`MIE_OP_INC, `MIE_OP_INCREMENT_TO_ACCUMULATOR,
                         `MIE_OP_DEC, `MIE_OP_DECREMENT_TO_ACCUMULATOR};
    logic [7:0] d[4] = '{8'hFF, 8'h7F, 8'h01, 8'h00};
    logic [7:0] r[4] = '{8'h00, 8'h80, 8'h00, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      op(k[i], 8'h00, d[i]);
      chk("incdec_we", we_s, !i[0]);
      chk("incdec_res", i[0] ? acc : wd_s, r[i]);
      chk("incdec_z", zero_flag, !i[0]);
      chk("incdec_c", carry_flag, c_m);
    end
    $display("test incdec done");
  endtask
  task t_rot;
    logic [7:0] d, r;
    logic       nc;
    for (int i = 0; i < 8; i++) begin
      d = i[0] ? 8'h42 : 8'h81;
      r = !i[2] ? {d[6:0], i[1] ? c_m : d[7]} : {i[1] ? c_m : d[0], d[7:1]};
      nc = i[1] ? (!i[2] ? d[7] : d[0]) : c_m;
      op(`MIE_OP_RL + i[4:0], 8'h00, d);
      chk("rot_we", we_s, !i[0]);
      chk("rot_res", i[0] ? acc : wd_s, r);
      chk("rot_c", carry_flag, nc);
      c_m = nc;
    end
    $display("test rotate done");
  endtask
  task t_sbc;
    logic [7:0] a[3] = '{8'h05, 8'h80, 8'h10};
    logic [7:0] b[3] = '{8'h06, 8'h01, 8'h10};
    logic [8:0] f;
    for (int i = 0; i < 3; i++) begin
      op(`MIE_OP_MOV_AX, a[i], 8'h00);
      op(i == 1 ? `MIE_OP_SBCM : `MIE_OP_SBC, 8'h00, b[i]);
      f = {1'b0, a[i]} - {1'b0, b[i]} - {8'h00, !c_m};
      chk("sbc_res", i == 1 ? wd_s : acc, f[7:0]);
      chk("sbc_c", carry_flag, !f[8]);
      chk("sbc_z", zero_flag, f[7:0] == 8'h00);
      chk("sbc_ov", signed_excess_flag,
          a[i][7] != b[i][7] && f[7] != a[i][7]);
      chk("sbc_ac", half_carry_flag,
          {1'b0, a[i][3:0]} >= {1'b0, b[i][3:0]} + !c_m);
      c_m = !f[8];
    end
    $display("test subtract done");
  endtask
  task t_logic;
    op(`MIE_OP_MOV_AX, 8'h50, 8'h00);
    op(`MIE_OP_OR_AX, 8'h0A, 8'h00);
    chk("or_imm", {zero_flag, acc}, {1'b0, 8'h5A});
    op(`MIE_OP_ORM, 8'h00, 8'h81);
    chk("or_mem", {we_s, wd_s, acc}, {1'b1, 8'hDB, 8'h5A});
    op(`MIE_OP_MOV_MA, 8'h00, 8'h00);
    chk("mov_ma", {we_s, wd_s}, {1'b1, 8'h5A});
    op(`MIE_OP_MOV_AM, 8'h00, 8'h00);
    chk("mov_am", {zero_flag, carry_flag, acc}, {1'b0, c_m, 8'h00});
    op(`MIE_OP_NOP, 8'h77, 8'h33);
    chk("nop", {we_s, acc, carry_flag}, {1'b0, 8'h00, c_m});
    $display("test logic done");
  endtask
  task t_flow;
    op(`MIE_OP_JUMP, 8'hA5, 8'h00);
    chk("jump", {dummy_slot, pc}, {1'b1, 11'h1A5});
    op(`MIE_OP_DSKIP, 8'h00, 8'h01);
    chk("skip_wr", {we_s, wd_s}, {1'b1, 8'h00});
    chk("skip_pc", {dummy_slot, pc}, {1'b1, 11'h1A7});
    op(`MIE_OP_DSKIP, 8'h00, 8'h05);
    chk("run_wr", wd_s, 8'h04);
    chk("run_pc", {dummy_slot, pc}, {1'b0, 11'h1A8});
    op(`MIE_OP_SUB_EXA, 8'h3C, 8'h00);
    chk("sub_exit", {pop_s, acc, pc}, {1'b1, 8'h3C, 11'h2AA});
    @(posedge clk) irq_pending <= 1'b1;
    op(`MIE_OP_IRQ_EXIT, 8'h00, 8'h00);
    chk("irq_exit", {pop_s, global_irq_enable}, 2'b11);
    chk("irq_serve", irq_service, 1'b1);
    @(posedge clk);
    irq_pending <= 1'b0;
    stack_top <= 11'h155;
    op(`MIE_OP_SUB_EXIT, 8'h00, 8'h00);
    chk("ret_plain", {pop_s, acc, pc}, {1'b1, 8'h3C, 11'h155});
    op(`MIE_OP_IRQ_EXIT, 8'h00, 8'h00);
    chk("irq_idle", {pop_s, irq_service}, 2'b10);
    $display("test flow done");
  endtask
  task t_pwr;
    op(`MIE_OP_MOV_AX, 8'h77, 8'h00);
    op(`MIE_OP_PWRDN, 8'h00, 8'h00);
    chk("pd_enter", {clock_off, power_down_flag, watchdog_expiry_flag,
        watchdog_clear}, 4'b1101);
    op(`MIE_OP_MOV_AX, 8'h11, 8'h00);
    chk("pd_hold", {clock_off, acc}, {1'b1, 8'h77});
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    repeat (2) @(posedge clk);
    op(`MIE_OP_MOV_AX, 8'h11, 8'h00);
    chk("pd_wake", {clock_off, acc}, {1'b0, 8'h11});
    $display("test power-down done");
  endtask
  initial begin
    #200us;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_bcd();
    t_incdec();
    t_rot();
    t_sbc();
    t_logic();
    t_flow();
    t_pwr();
    end_sim();
  end
endmodule
`default_nettype wire
